// File: vls_host_model.sv
// host model issuing word transfers on the link command port
`timescale 1ns/1ps
`default_nettype none
module vls_host_model (
  input  wire logic        linkClk,
  input  wire logic        linkBusy,
  input  wire logic        linkDone,
  input  wire logic [15:0] linkRdData,
  output var  logic        linkWrEn = 1'b0,
  output var  logic        linkRdEn = 1'b0,
  output var  logic [7:0]  linkCmd = 8'hFF,
  output var  logic [15:0] linkWrData = 16'hFFFF
);
  logic late = 1'b0;
  task automatic xfer(input logic r, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge linkClk);
    linkWrEn <= ~r;
    linkRdEn <= r;
    linkCmd <= c;
    linkWrData <= d;
    // release only once busy shows, else the done edge takes it again
    while (linkBusy !== 1'b1 && n < 12) begin
      @(posedge linkClk);
      n++;
    end
    linkWrEn <= 1'b0;
    linkRdEn <= 1'b0;
    linkCmd <= ~c;
    linkWrData <= ~d;
    while (linkDone !== 1'b1 && n < 12) begin
      @(posedge linkClk);
      n++;
    end
    q = linkRdData;
    if (n >= 12) late = 1'b1;
  endtask
endmodule // vls_host_model
`default_nettype wire

// File: vls_pkg.sv
// types shared by the output limit, slew and scale register bank
package vls_pkg;
  typedef logic [15:0] vls_word_t;
  typedef logic [2:0]  vls_rate_t;
  typedef logic [7:0]  vls_cmd_t;
endpackage

// File: vls_regs.sv
// output ceiling, slew-rate and feedback-scale registers behind a pmbus port
`timescale 1ns/1ps
`default_nettype none
`include "vls_regs_defs.svh"

module vls_regs (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            linkClk,
  input  wire logic            linkRst_n,
  input  wire logic            linkWrEn,
  input  wire logic            linkRdEn,
  input  wire vls_pkg::vls_cmd_t  linkCmd,
  input  wire vls_pkg::vls_word_t linkWrData,
  output var  logic            linkBusy,
  output var  logic            linkDone,
  output var  vls_pkg::vls_word_t linkRdData,
  input  wire vls_pkg::vls_word_t voutSetpoint,
  input  wire logic            softRampActive,
  output var  vls_pkg::vls_word_t outputCeiling,
  output var  vls_pkg::vls_rate_t slewSelect,
  output var  logic            slewApply,
  output var  logic [2:0]      scaleMantissa,
  output var  logic [2:0]      nvScale,
  output var  logic            nvStorePulse,
  output var  logic            cmlFault,
  output var  logic            ivdFault,
  output var  logic            smbAlert_n
);

  function automatic vls_pkg::vls_rate_t slewBucket(input logic [6:0] m);
    if (m <= `VLS_SLEW_T0) slewBucket = 3'h0;
    else if (m <= `VLS_SLEW_T1) slewBucket = 3'h1;
    else if (m <= `VLS_SLEW_T2) slewBucket = 3'h2;
    else if (m <= `VLS_SLEW_T3) slewBucket = 3'h3;
    else if (m <= `VLS_SLEW_T4) slewBucket = 3'h4;
    else if (m <= `VLS_SLEW_T5) slewBucket = 3'h5;
    else if (m <= `VLS_SLEW_T6) slewBucket = 3'h6;
    else slewBucket = 3'h7;
  endfunction

  // ---------------- link domain ----------------
  logic               lReqTog_q;
  logic               lBusy_q;
  logic               lDone_q;
  logic               lIsRd_q;
  vls_pkg::vls_cmd_t  lCmd_q;
  vls_pkg::vls_word_t lData_q;
  vls_pkg::vls_word_t lRdData_q;
  logic               lAckS1_q;
  logic               lAckS2_q;
  logic               lAckS3_q;
  logic               sAckTog_q;
  vls_pkg::vls_word_t sRdWord_q;

  wire lTake = !lBusy_q && (linkWrEn || linkRdEn);
  wire lAck  = lAckS2_q ^ lAckS3_q;

  // command and data are held stable until the ack comes back, so the
  // system side can read them as a bundle without a word synchroniser
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      lReqTog_q <= 1'b0;
      lBusy_q   <= 1'b0;
      lDone_q   <= 1'b0;
      lIsRd_q   <= 1'b0;
      lCmd_q    <= 8'h00;
      lData_q   <= 16'h0000;
      lRdData_q <= 16'h0000;
      lAckS1_q  <= 1'b0;
      lAckS2_q  <= 1'b0;
      lAckS3_q  <= 1'b0;
    end else begin
      lAckS1_q <= sAckTog_q;
      lAckS2_q <= lAckS1_q;
      lAckS3_q <= lAckS2_q;
      lDone_q  <= lAck;
      if (lTake) begin
        lReqTog_q <= ~lReqTog_q;
        lBusy_q   <= 1'b1;
        lIsRd_q   <= linkRdEn;
        lCmd_q    <= linkCmd;
        lData_q   <= linkWrData;
      end else if (lAck) begin
        lBusy_q   <= 1'b0;
        lRdData_q <= sRdWord_q;
      end
    end
  end

  assign linkBusy   = lBusy_q;
  assign linkDone   = lDone_q;
  assign linkRdData = lRdData_q;

  // ---------------- system domain ----------------
  logic               sReqS1_q;
  logic               sReqS2_q;
  logic               sReqS3_q;
  vls_pkg::vls_word_t ceil_q;
  logic [6:0]         slew_q;
  logic [2:0]         scale_q;
  logic [2:0]         nv_q;
  logic               nvPulse_q;
  logic               cml_q;
  logic               ivd_q;
  logic               alertN_q;
  vls_pkg::vls_rate_t rate_q;
  logic               apply_q;

  wire sReq = sReqS2_q ^ sReqS3_q;
  wire sWr  = sReq && !lIsRd_q;

  wire isCeil  = (lCmd_q == `VLS_CMD_CEILING);
  wire isSlew  = (lCmd_q == `VLS_CMD_SLEW);
  wire isScale = (lCmd_q == `VLS_CMD_SCALE);
  wire isClr   = (lCmd_q == `VLS_CMD_CLEAR_FAULTS);
  wire isStore = (lCmd_q == `VLS_CMD_STORE_ALL);

  vls_pkg::vls_word_t ceilMin;
  vls_pkg::vls_word_t ceilMax;
  assign ceilMin = (scale_q == `VLS_SCALE_QUARTER) ? `VLS_CEIL_MIN_X025 :
                   (scale_q == `VLS_SCALE_HALF)    ? `VLS_CEIL_MIN_X05 :
                                                     `VLS_CEIL_MIN_X1;
  assign ceilMax = (scale_q == `VLS_SCALE_QUARTER) ? `VLS_CEIL_MAX_X025 :
                   (scale_q == `VLS_SCALE_HALF)    ? `VLS_CEIL_MAX_X05 :
                                                     `VLS_CEIL_MAX_X1;

  // full 16-bit word is the mantissa; exponent lives in the mode word
  wire ceilOutRange = (lData_q < ceilMin) || (lData_q > ceilMax);
  wire ceilAbove    = (lData_q > voutSetpoint);
  wire ceilClamp    = ceilOutRange && ceilAbove;
  wire ceilAccept   = !ceilOutRange && ceilAbove;
  wire ceilBad      = isCeil && sWr && !ceilAccept;

  // only the three writable mantissa bits are judged; the rest are ignored
  wire [2:0] scaleNew  = lData_q[2:0];
  wire scaleOk = (scaleNew == `VLS_SCALE_ONE) ||
                 (scaleNew == `VLS_SCALE_HALF) ||
                 (scaleNew == `VLS_SCALE_QUARTER);
  wire scaleBad = isScale && sWr && !scaleOk;
  wire badEvt   = ceilBad || scaleBad;
  wire clrEvt   = isClr && sWr;

  vls_pkg::vls_word_t rdMux;
  assign rdMux =
    (lCmd_q == `VLS_CMD_VOUT_MODE) ? `VLS_VOUT_MODE_VAL :
    isCeil  ? ceil_q :
    isSlew  ? {`VLS_SLEW_EXP, 4'h0, slew_q} :
    isScale ? {`VLS_SCALE_EXP, 8'h00, scale_q} :
    (lCmd_q == `VLS_CMD_STATUS_BYTE) ?
      16'(cml_q) << `VLS_STAT_BYTE_CML_BIT :
    (lCmd_q == `VLS_CMD_STATUS_CML) ?
      16'(ivd_q) << `VLS_STAT_CML_IVD_BIT :
    16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sReqS1_q  <= 1'b0;
      sReqS2_q  <= 1'b0;
      sReqS3_q  <= 1'b0;
      sAckTog_q <= 1'b0;
      sRdWord_q <= 16'h0000;
    end else begin
      sReqS1_q <= lReqTog_q;
      sReqS2_q <= sReqS1_q;
      sReqS3_q <= sReqS2_q;
      if (sReq) begin
        sRdWord_q <= rdMux;
        sAckTog_q <= ~sAckTog_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ceil_q  <= `VLS_CEIL_MAX_X1;
      slew_q  <= `VLS_SLEW_RST;
      scale_q <= `VLS_SCALE_ONE;
    end else if (sWr) begin
      if (isCeil && ceilAccept)
        ceil_q <= lData_q;
      else if (isCeil && ceilClamp)
        ceil_q <= ceilMax;
      if (isSlew)
        slew_q <= lData_q[6:0];
      if (isScale && scaleOk)
        scale_q <= scaleNew;
    end
  end

  // faults: a new bad write in the same cycle as a clear wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cml_q    <= 1'b0;
      ivd_q    <= 1'b0;
      alertN_q <= 1'b1;
    end else if (badEvt) begin
      cml_q    <= 1'b1;
      ivd_q    <= 1'b1;
      alertN_q <= 1'b0;
    end else if (clrEvt) begin
      cml_q    <= 1'b0;
      ivd_q    <= 1'b0;
      alertN_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nv_q      <= `VLS_SCALE_ONE;
      nvPulse_q <= 1'b0;
    end else begin
      nvPulse_q <= isStore && sWr;
      if (isStore && sWr)
        nv_q <= scale_q;
    end
  end

  // soft start and stop ramps run from their own timing, not this rate
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rate_q  <= 3'h6;
      apply_q <= 1'b0;
    end else begin
      rate_q  <= slewBucket(slew_q);
      apply_q <= !softRampActive;
    end
  end

  assign outputCeiling = ceil_q;
  assign slewSelect    = rate_q;
  assign slewApply     = apply_q;
  assign scaleMantissa = scale_q;
  assign nvScale       = nv_q;
  assign nvStorePulse  = nvPulse_q;
  assign cmlFault      = cml_q;
  assign ivdFault      = ivd_q;
  assign smbAlert_n    = alertN_q;

endmodule // vls_regs
`default_nettype wire

// File: vls_regs_bench.sv
// self-checking bench of the output limit, slew and scale register bank
`timescale 1ns/1ps
`default_nettype none
module vls_regs_bench;
  logic        clk_sys = 1'b0;
  logic        linkClk = 1'b0;
  logic        rst_n = 1'b0;
  logic        linkRst_n = 1'b0;
  logic        softRampActive = 1'b0;
  logic [15:0] voutSetpoint = 16'h0100;
  logic        linkWrEn, linkRdEn, linkBusy, linkDone, slewApply;
  logic        nvStorePulse, cmlFault, ivdFault, smbAlert_n;
  logic [7:0]  linkCmd;
  logic [15:0] linkWrData, linkRdData, outputCeiling, q;
  logic [2:0]  slewSelect, scaleMantissa, nvScale;
  logic [6:0]  sw [11] = '{7'h00, 7'h05, 7'h06, 7'h07, 7'h0C, 7'h0D,
                          7'h11, 7'h19, 7'h2F, 7'h4F, 7'h50};
  logic [2:0]  sb [11] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3,
                          3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int          fails = 0;
  int          checks = 0;
  always #2 clk_sys = ~clk_sys;
  always #62.5 linkClk = ~linkClk;
  vls_regs DUT (.*);
  vls_host_model host (.*);
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic io(logic r, logic [7:0] c, logic [15:0] d);
    host.xfer(r, c, d, q);
    if (host.late) begin
      fails++;
      report_and_stop();
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rd(logic [7:0] c, logic [15:0] e);
    io(1'b1, c, 16'h0000);
    chk($sformatf("command %h", c), e, q);
  endtask
  // checks alert, cml and ivd, then clears the flags for the next case
  task automatic flt(logic f);
    chk("alert", 16'(!f), 16'(smbAlert_n));
    chk("cml", 16'(f), 16'(cmlFault));
    chk("ivd", 16'(f), 16'(ivdFault));
    io(1'b0, 8'h03, 16'h0000);
  endtask
  task automatic cw(logic [15:0] d, logic [15:0] e, logic f);
    io(1'b0, 8'h24, d);
    chk("ceiling", e, outputCeiling);
    flt(f);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge linkClk);
    linkRst_n <= 1'b1;
    rd(8'h24, 16'h0300);
    rd(8'h27, 16'hD03C);
    rd(8'h29, 16'hF004);
    rd(8'h20, 16'h0017);
    rd(8'h55, 16'h0000);
    chk("bucket", 16'h0006, 16'(slewSelect));
    for (int i = 0; i < 11; i++) begin
      io(1'b0, 8'h27, {9'h1FF, sw[i]});
      chk("bucket", 16'(sb[i]), 16'(slewSelect));
    end
    rd(8'h27, 16'hD050);
    @(posedge clk_sys) softRampActive <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("apply", 16'h0000, 16'(slewApply));
    softRampActive <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("apply", 16'h0001, 16'(slewApply));
    io(1'b0, 8'h29, 16'hFFF3);
    chk("scale", 16'h0004, 16'(scaleMantissa));
    rd(8'h78, 16'h0002);
    rd(8'h7E, 16'h0080);
    flt(1'b1);
    io(1'b0, 8'h29, 16'hFFF2);
    rd(8'h29, 16'hF002);
    cw(16'h0234, 16'h0234, 1'b0);
    cw(16'h0233, 16'h0600, 1'b1);
    @(posedge clk_sys) voutSetpoint <= 16'h0300;
    cw(16'h0250, 16'h0600, 1'b1);
    @(posedge clk_sys) voutSetpoint <= 16'h0100;
    io(1'b0, 8'h11, 16'h0000);
    chk("stored scale", 16'h0002, 16'(nvScale));
    io(1'b0, 8'h29, 16'hF001);
    cw(16'h0468, 16'h0468, 1'b0);
    cw(16'h0C01, 16'h0C00, 1'b1);
    io(1'b0, 8'h29, 16'hF004);
    cw(16'h011A, 16'h011A, 1'b0);
    cw(16'h0301, 16'h0300, 1'b1);
    report_and_stop();
  end
endmodule // vls_regs_bench
bind vls_regs vls_regs_monitor u_mon (.*);
`default_nettype wire

// File: vls_regs_defs.svh
// constants of the output ceiling, slew-rate and feedback-scale registers
// Contract
// - ceiling exponent is fixed at -9, about 1.95 mV per count
// - scale one: ceiling accepts 282 to 768, resets to 768
// - scale one half: ceiling accepts 564 to 1536, default 1536
// - scale one quarter: ceiling accepts 1128 to 3072, default 3072
// - slew applies to normal and turn-off-delay moves, not soft ramps
// - exactly eight fixed slew rates; programmed value rounds to nearest one
// - slew exponent fixed at -6; only seven low mantissa bits writable
// - slew mantissa resets to 60, one millivolt per microsecond
// - slew thresholds 5,7,12,17,25,47,79 upper-inclusive pick rates 0 to 7
// - scale accepts only one, one half, one quarter; resets to one
// - other scale write: keep scale, set cml and ivd, raise alert
// - store-all-defaults copies scale into nonvolatile storage
// - scale exponent fixed read-only at -2; three low mantissa bits writable
// - scale mantissa 4 is one, 2 is half, 1 is quarter; reset 4
// - out-of-range ceiling above setpoint is replaced by scale maximum
// - in-range ceiling below setpoint leaves stored ceiling unchanged
// - both bad ceiling cases set cml and ivd and raise alert
`ifndef VLS_REGS_DEFS_SVH
`define VLS_REGS_DEFS_SVH

`define VLS_CMD_CLEAR_FAULTS  8'h03
`define VLS_CMD_STORE_ALL     8'h11
`define VLS_CMD_VOUT_MODE     8'h20
`define VLS_CMD_CEILING       8'h24
`define VLS_CMD_SLEW          8'h27
`define VLS_CMD_SCALE         8'h29
`define VLS_CMD_STATUS_BYTE   8'h78
`define VLS_CMD_STATUS_CML    8'h7E

`define VLS_VOUT_MODE_VAL     16'h0017
`define VLS_STAT_BYTE_CML_BIT 1
`define VLS_STAT_CML_IVD_BIT  7

`define VLS_CEIL_MIN_X1       16'h011A
`define VLS_CEIL_MAX_X1       16'h0300
`define VLS_CEIL_MIN_X05      16'h0234
`define VLS_CEIL_MAX_X05      16'h0600
`define VLS_CEIL_MIN_X025     16'h0468
`define VLS_CEIL_MAX_X025     16'h0C00

`define VLS_SLEW_EXP          5'h1A
`define VLS_SLEW_RST          7'h3C
`define VLS_SLEW_T0           7'h05
`define VLS_SLEW_T1           7'h07
`define VLS_SLEW_T2           7'h0C
`define VLS_SLEW_T3           7'h11
`define VLS_SLEW_T4           7'h19
`define VLS_SLEW_T5           7'h2F
`define VLS_SLEW_T6           7'h4F

`define VLS_SCALE_EXP         5'h1E
`define VLS_SCALE_ONE         3'h4
`define VLS_SCALE_HALF        3'h2
`define VLS_SCALE_QUARTER     3'h1

`endif

// File: vls_regs_monitor.sv
// port checker of the output limit, slew and scale register bank
`timescale 1ns/1ps
`default_nettype none
module vls_regs_monitor (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        linkClk,
  input wire logic        linkRst_n,
  input wire logic        linkBusy,
  input wire logic        linkDone,
  input wire logic [15:0] voutSetpoint,
  input wire logic        softRampActive,
  input wire logic [15:0] outputCeiling,
  input wire logic        slewApply,
  input wire logic [2:0]  scaleMantissa,
  input wire logic [2:0]  nvScale,
  input wire logic        nvStorePulse,
  input wire logic        cmlFault,
  input wire logic        ivdFault,
  input wire logic        smbAlert_n
);
  // ceiling limits grow 1/2/4 times as the divider ratio halves
  wire [15:0] mult = {13'h0000, scaleMantissa[0], scaleMantissa[1],
                      scaleMantissa[2]};
  sequence s_take; $rose(linkBusy); endsequence
  sequence s_answer; ##[1:5] linkDone; endsequence
  property p_reset_vals;
    @(posedge clk_sys) disable iff (!rst_n) $rose(rst_n) |->
      outputCeiling == 16'h0300 && scaleMantissa == 3'h4 && smbAlert_n;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong state after reset");
  property p_range;
    @(posedge clk_sys) disable iff (!rst_n) $changed(outputCeiling) |->
      outputCeiling >= 16'h011A * mult && outputCeiling <= 16'h0300 * mult;
  endproperty
  a_range: assert property (p_range)
    else $error("ceiling stored outside its scale range");
  property p_above_sp;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(outputCeiling) |-> outputCeiling > voutSetpoint;
  endproperty
  a_above_sp: assert property (p_above_sp)
    else $error("ceiling stored at or below setpoint");
  property p_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(cmlFault) |-> ##[0:2] (ivdFault && !smbAlert_n);
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault without ivd and alert");
  property p_legal;
    @(posedge clk_sys) disable iff (!rst_n) scaleMantissa inside {1, 2, 4};
  endproperty
  a_legal: assert property (p_legal)
    else $error("scale holds an illegal code");
  property p_store;
    @(posedge clk_sys) disable iff (!rst_n)
      nvStorePulse |-> nvScale == scaleMantissa ##1 !nvStorePulse;
  endproperty
  a_store: assert property (p_store)
    else $error("stored scale differs or pulse too long");
  property p_apply;
    @(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) |-> slewApply == !$past(softRampActive);
  endproperty
  a_apply: assert property (p_apply)
    else $error("slew applied during a soft ramp");
  property p_answer;
    @(posedge linkClk) disable iff (!linkRst_n) s_take |-> s_answer;
  endproperty
  a_answer: assert property (p_answer)
    else $error("link transfer not answered in time");
endmodule // vls_regs_monitor
`default_nettype wire
